// >>> rtl/fsh_flash_ctrl.sv
/*
 * SPI-side control of a small serial flash: mode 0/3 shifting, pause
 * function, write protection and the two status registers.
 * Assumes all pins are asynchronous and the serial clock is at most
 * one eighth of clk; the array engine sits behind the exec_* outputs.
 */
`timescale 1ns/1ps
module fsh_flash_ctrl
    import fsh_pkg::*;
#(
    parameter int CNT_W = 20,
    parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
    parameter int CHIP_CYCLES = CHIP_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_out,
    output logic so_oe_n,
    output logic exec_strobe,
    output logic [7:0] exec_opcode,
    output logic [ADDR_W-1:0] exec_addr,
    output logic [15:0] exec_data
);
    logic ce_n_s, sck_s, si_s, hold_n_s, wp_n_s;
    logic sck_prev, ce_n_prev, paused;
    fsh_state_t state;
    logic [2:0] bit_cnt, out_idx;
    logic [6:0] in_shift;
    logic [7:0] opcode, snap;
    logic [1:0] addr_cnt, data_cnt;
    logic [23:0] addr_sr;
    logic [7:0] data_b0, data_b1;
    logic read_started;
    logic write_enable_latch, auto_inc, bp_lo, bp_hi, lockdown, top_lock, bot_lock;
    logic [CNT_W-1:0] busy_cnt;
    logic op_is_auto;
    logic [ADDR_W-1:0] auto_addr;

    // Pins are async to clk; slow serial clock makes its edges visible here
    // Reset to idle levels: deselected, clock high, input low, pause and lock released
    fsh_sync #(
        .WIDTH(5),
        .RESET_VALUE(5'h1B)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({ce_n, sck, si, hold_n, wp_n}),
        .sync_out({ce_n_s, sck_s, si_s, hold_n_s, wp_n_s})
    );

    wire selected = ~ce_n_s;
    // Limitation: each serial clock phase must last about four clk or an edge is lost
    wire sck_rise = sck_s & ~sck_prev;
    wire sck_fall = ~sck_s & sck_prev;
    wire frame_end = ce_n_s & ~ce_n_prev;
    wire active = selected & ~paused;
    wire shift_rise = active & sck_rise;
    wire shift_fall = active & sck_fall;
    wire [7:0] next_byte = {in_shift, si_s};
    wire byte_done = shift_rise & (bit_cnt == 3'h7);
    wire busy = (busy_cnt != '0);
    wire whole_bytes = (bit_cnt == 3'h0);

    wire [7:0] status1 = {lockdown, auto_inc, 2'b00, bp_hi, bp_lo, write_enable_latch, busy};
    wire [7:0] status2 = {4'h0, bot_lock, top_lock, 2'b00};
    wire [7:0] live_status = (opcode == OP_STATUS2_READ) ? status2 : status1;

    wire is_status_rd = (next_byte == OP_STATUS_READ) || (next_byte == OP_STATUS2_READ);
    wire is_addr_op = (next_byte == OP_BYTE_PROG) || (next_byte == OP_SECTOR_ERASE)
        || (next_byte == OP_BLOCK32_ERASE) || (next_byte == OP_BLOCK64_ERASE)
        || ((next_byte == OP_AUTO_INC_PROG) && !auto_inc);
    wire is_data_op = (next_byte == OP_STATUS_WRITE)
        || ((next_byte == OP_AUTO_INC_PROG) && auto_inc);
    wire op_has_data = (opcode == OP_BYTE_PROG) || (opcode == OP_AUTO_INC_PROG);

    function automatic logic region_hit(
        input logic [ADDR_W-1:0] lo,
        input logic [ADDR_W-1:0] hi,
        input logic [1:0] bp,
        input logic tlock,
        input logic block
    );
        logic [ADDR_W-1:0] base;
        logic hit;
        base = PROT_FULL_BASE;
        case (bp)
            2'b01: base = PROT_QUARTER_BASE;
            2'b10: base = PROT_HALF_BASE;
            default: base = PROT_FULL_BASE;
        endcase
        hit = (bp != 2'b00) && (hi >= base);
        hit = hit || (tlock && (hi >= TOP_SECTOR_BASE));
        hit = hit || (block && (lo <= BOT_SECTOR_END));
        return hit;
    endfunction : region_hit

    // Target range of the command that ends this frame
    wire [ADDR_W-1:0] cmd_addr = auto_inc ? auto_addr : addr_sr[ADDR_W-1:0];
    wire [ADDR_W-1:0] range_mask =
        (opcode == OP_SECTOR_ERASE) ? SECTOR_MASK :
        (opcode == OP_BLOCK32_ERASE) ? BLOCK32_MASK :
        (opcode == OP_BLOCK64_ERASE) ? BLOCK64_MASK :
        (opcode == OP_AUTO_INC_PROG) ? ADDR_W'(1) : '0;
    wire is_chip = (opcode == OP_CHIP_ERASE_A) || (opcode == OP_CHIP_ERASE_B);
    wire [ADDR_W-1:0] range_lo = is_chip ? '0 : (cmd_addr & ~range_mask);
    wire [ADDR_W-1:0] range_hi = is_chip ? ARRAY_TOP : (cmd_addr | range_mask);
    wire prot_hit = region_hit(range_lo, range_hi, {bp_hi, bp_lo}, top_lock, bot_lock);

    wire [ADDR_W-1:0] next_auto_addr = range_lo + WORD_STEP;
    wire auto_last = (range_hi == ARRAY_TOP)
        || region_hit(next_auto_addr, next_auto_addr | ADDR_W'(1), {bp_hi, bp_lo}, top_lock, bot_lock);

    wire form_ok =
        ((opcode == OP_BYTE_PROG) && (addr_cnt == 2'(ADDR_BYTES)) && (data_cnt != 2'd0)) ||
        (((opcode == OP_SECTOR_ERASE) || (opcode == OP_BLOCK32_ERASE) || (opcode == OP_BLOCK64_ERASE))
            && (addr_cnt == 2'(ADDR_BYTES))) ||
        (is_chip && (state == S_IGNORE)) ||
        ((opcode == OP_AUTO_INC_PROG) && (data_cnt == 2'd2)
            && (auto_inc || (addr_cnt == 2'(ADDR_BYTES))));

    // Commands only act at deselect on a byte boundary; a partial byte aborts
    wire cmd_end = frame_end & whole_bytes & (state != S_READ) & (state != S_OPCODE) & ~busy;
    wire do_exec = cmd_end & form_ok & write_enable_latch & ~prot_hit;
    wire do_wren = cmd_end & (opcode == OP_WRITE_ENABLE);
    wire do_write_disable_cmd = cmd_end & (opcode == OP_WRITE_DISABLE);
    wire do_status_write_cmd = cmd_end & (opcode == OP_STATUS_WRITE) & (data_cnt != 2'd0);
    wire status_write_cmd_allowed = wp_n_s | ~lockdown;
    wire op_done = (busy_cnt == CNT_W'(1));

    wire [CNT_W-1:0] exec_cycles =
        is_chip ? CNT_W'(CHIP_CYCLES) :
        op_has_data ? CNT_W'(PROG_CYCLES) : CNT_W'(ERASE_CYCLES);

    // Edge history for the serial clock and select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Same level as the synchroniser reset, so no false edge follows reset
            sck_prev <= 1'b1;
            ce_n_prev <= 1'b1;
        end else begin
            sck_prev <= sck_s;
            ce_n_prev <= ce_n_s;
        end
    end

    // While selected, pause tracks the pin only while the clock is low, so a change with the
    // clock high waits for the next low phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            paused <= 1'b0;
        end else if (!selected) begin
            paused <= paused & ~hold_n_s;
        end else if (!sck_s) begin
            paused <= ~hold_n_s;
        end
    end

    // Command shifter; frozen while paused so the sequence resumes intact
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_OPCODE;
            bit_cnt <= 3'h0;
            in_shift <= 7'h00;
            opcode <= 8'h00;
            addr_cnt <= 2'd0;
            data_cnt <= 2'd0;
            addr_sr <= 24'h000000;
            data_b0 <= 8'h00;
            data_b1 <= 8'h00;
        end else if (!selected) begin
            state <= S_OPCODE;
            bit_cnt <= 3'h0;
            addr_cnt <= 2'd0;
            data_cnt <= 2'd0;
        end else if (shift_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            in_shift <= next_byte[6:0];
            if (byte_done) begin
                case (state)
                    S_OPCODE: begin
                        opcode <= next_byte;
                        if (busy && !is_status_rd) begin
                            state <= S_IGNORE;
                        end else if (is_status_rd) begin
                            state <= S_READ;
                        end else if (is_addr_op) begin
                            state <= S_ADDR;
                        end else if (is_data_op) begin
                            state <= S_DATA;
                        end else begin
                            state <= S_IGNORE;
                        end
                    end
                    S_ADDR: begin
                        addr_sr <= {addr_sr[15:0], next_byte};
                        addr_cnt <= addr_cnt + 2'd1;
                        if (addr_cnt == 2'(ADDR_BYTES - 1)) begin
                            state <= op_has_data ? S_DATA : S_IGNORE;
                        end
                    end
                    S_DATA: begin
                        if (data_cnt == 2'd0) begin
                            data_b0 <= next_byte;
                        end else if (data_cnt == 2'd1) begin
                            data_b1 <= next_byte;
                        end
                        if (data_cnt != 2'd2) begin
                            data_cnt <= data_cnt + 2'd1;
                        end
                    end
                    default: state <= state;
                endcase
            end
        end
    end

    // Status output: new bit after each falling edge, byte snapshot repeats
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            so_out <= 1'b0;
            so_oe_n <= 1'b1;
            out_idx <= 3'h7;
            snap <= 8'h00;
            read_started <= 1'b0;
        end else begin
            so_oe_n <= ~(active & (state == S_READ) & (read_started | shift_fall));
            if (!selected) begin
                out_idx <= 3'h7;
                read_started <= 1'b0;
            end else if (shift_fall && state == S_READ) begin
                read_started <= 1'b1;
                out_idx <= out_idx - 3'h1;
                if (out_idx == 3'h7) begin
                    snap <= live_status;
                    so_out <= live_status[7];
                end else begin
                    so_out <= snap[out_idx];
                end
            end
        end
    end

    // Internal operation timer drives the busy bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= '0;
            op_is_auto <= 1'b0;
        end else if (do_exec) begin
            busy_cnt <= exec_cycles;
            op_is_auto <= (opcode == OP_AUTO_INC_PROG);
        end else if (busy) begin
            busy_cnt <= busy_cnt - CNT_W'(1);
        end
    end

    // Write-enable latch and auto-increment mode
    // Auto-increment keeps the latch between words; the last word clears it at acceptance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch <= 1'b0;
            auto_inc <= 1'b0;
            auto_addr <= '0;
        end else begin
            if (do_wren) begin
                write_enable_latch <= 1'b1;
            end else if (do_write_disable_cmd || do_status_write_cmd) begin
                write_enable_latch <= 1'b0;
                auto_inc <= auto_inc & ~do_write_disable_cmd;
            end else if (do_exec && opcode == OP_AUTO_INC_PROG) begin
                auto_inc <= ~auto_last;
                auto_addr <= next_auto_addr;
                write_enable_latch <= ~auto_last;
            end else if (op_done && !op_is_auto) begin
                write_enable_latch <= 1'b0;
            end
        end
    end

    // Status register write; reserved positions of the data are dropped
    // A refused write still clears the latch, so the host must enable writes again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_lo <= BP_RESET;
            bp_hi <= BP_RESET;
            lockdown <= LOCK_RESET;
            top_lock <= 1'b0;
            bot_lock <= 1'b0;
        end else if (do_status_write_cmd && status_write_cmd_allowed) begin
            bp_lo <= data_b0[SR_BP_LO];
            bp_hi <= data_b0[SR_BP_HI];
            lockdown <= data_b0[SR_LOCKDOWN];
            if (data_cnt == 2'd2) begin
                top_lock <= data_b1[SR2_TOP];
                bot_lock <= data_b1[SR2_BOT];
            end
        end
    end

    // Hand-off to the array engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exec_strobe <= 1'b0;
            exec_opcode <= 8'h00;
            exec_addr <= '0;
            exec_data <= 16'h0000;
        end else begin
            exec_strobe <= do_exec;
            if (do_exec) begin
                exec_opcode <= opcode;
                exec_addr <= range_lo;
                exec_data <= {data_b1, data_b0};
            end
        end
    end
endmodule : fsh_flash_ctrl

// >>> rtl/fsh_pkg.sv
/*
 * Shared constants for the serial flash control block: opcodes,
 * status bit positions, power-up values, array map and timing.
 * Assumes an 18-bit byte address space and a 10 MHz system clock.
 */
package fsh_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS = 7000;
    localparam int ERASE_TIME_NS = 18000000;
    localparam int CHIP_TIME_NS = 35000000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CHIP_CYCLES_DEF = (CHIP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_BYTE_PROG = 8'h02;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_STATUS2_READ = 8'h35;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_AUTO_INC_PROG = 8'hAD;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;

    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 3;
    localparam int SR_AUTO_INC = 6;
    localparam int SR_LOCKDOWN = 7;
    localparam int SR2_TOP = 2;
    localparam int SR2_BOT = 3;
    localparam logic BP_RESET = 1'b1;
    localparam logic LOCK_RESET = 1'b0;

    localparam int ADDR_W = 18;
    localparam int ADDR_BYTES = 3;
    localparam logic [ADDR_W-1:0] ARRAY_TOP = 18'h3FFFF;
    localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 18'h30000;
    localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 18'h20000;
    localparam logic [ADDR_W-1:0] PROT_FULL_BASE = 18'h00000;
    localparam logic [ADDR_W-1:0] SECTOR_MASK = 18'h00FFF;
    localparam logic [ADDR_W-1:0] BLOCK32_MASK = 18'h07FFF;
    localparam logic [ADDR_W-1:0] BLOCK64_MASK = 18'h0FFFF;
    localparam logic [ADDR_W-1:0] TOP_SECTOR_BASE = 18'h3F000;
    localparam logic [ADDR_W-1:0] BOT_SECTOR_END = 18'h00FFF;
    localparam logic [ADDR_W-1:0] WORD_STEP = 18'h00002;

    typedef enum logic [2:0] {S_OPCODE, S_ADDR, S_DATA, S_READ, S_IGNORE} fsh_state_t;
endpackage : fsh_pkg

// >>> rtl/fsh_sync.sv
/*
 * Two-flop synchroniser, one stage pair per bit.
 * Assumes inputs are asynchronous to clk; reset value is a parameter.
 */
`timescale 1ns/1ps
module fsh_sync #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta[i] <= RESET_VALUE[i];
                    sync_out[i] <= RESET_VALUE[i];
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule : fsh_sync

// >>> verification/fsh_flash_ctrl_props.sv
/* Concurrent checks on the ports of the serial flash control block.
   Assumes one clk domain and the asynchronous active-low rst_n. */
`timescale 1ns/1ps
module fsh_flash_ctrl_props
    import fsh_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_out,
    input wire logic so_oe_n,
    input wire logic exec_strobe,
    input wire logic [7:0] exec_opcode,
    input wire logic [ADDR_W-1:0] exec_addr,
    input wire logic [15:0] exec_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Pins pass two sync flops, so runs leave room for that lag
    sequence s_deselected;
        ce_n [*5];
    endsequence
    sequence s_paused_low;
        (!ce_n && !hold_n && !sck) [*6];
    endsequence
    a_oe_deselect: assert property (s_deselected |-> so_oe_n)
        else $error("serial output driven while deselected");
    a_pause_floats: assert property (s_paused_low |-> so_oe_n)
        else $error("serial output driven while paused");
    a_out_after_fall: assert property (!so_oe_n && $past(!so_oe_n) && $changed(so_out) |-> !$past(sck, 3))
        else $error("serial output changed without a falling clock");
    a_oe_needs_select: assert property ($fell(so_oe_n) |-> !$past(ce_n, 2) && $past(hold_n, 2))
        else $error("output enabled without select");
    a_strobe_framed: assert property (exec_strobe |-> ce_n && $past(ce_n, 2))
        else $error("command launched inside a frame");
    a_strobe_single: assert property (exec_strobe |=> !exec_strobe [*8])
        else $error("second command while busy");
    a_chip_at_zero: assert property (exec_strobe && (exec_opcode == OP_CHIP_ERASE_A ||
        exec_opcode == OP_CHIP_ERASE_B) |-> exec_addr == PROT_FULL_BASE)
        else $error("chip erase with nonzero range start");
    a_sector_base: assert property (exec_strobe && exec_opcode == OP_SECTOR_ERASE |->
        (exec_addr & SECTOR_MASK) == '0)
        else $error("sector erase not at a sector base");
endmodule : fsh_flash_ctrl_props

// >>> verification/fsh_flash_ctrl_tb_top.sv
/* Self-checking bench for the serial flash control block.
   Assumes the SPI host model drives all pins; erase counts are shortened. */
`timescale 1ns/1ps
module fsh_flash_ctrl_tb_top
    import fsh_pkg::*;
;
    typedef struct {logic [7:0] op; logic [1:0] bp; logic [1:0] lk; logic [17:0] a; bit ok;} fsh_case_t;
    logic clk;
    logic rst_n;
    logic ce_n, sck, si, hold_n, wp_n, so_out, so_oe_n, exec_strobe;
    logic [7:0] exec_opcode;
    logic [ADDR_W-1:0] exec_addr;
    logic [15:0] exec_data;
    logic [7:0] exp_rd [$];
    logic [41:0] exp_ex [$];
    fsh_case_t tc [14];
    int n_fail = 0;
    int n_compared = 0;
    initial clk = 1'b0;
    always #50 clk = ~clk;
    fsh_flash_ctrl #(.ERASE_CYCLES(200), .CHIP_CYCLES(300)) uut (.clk(clk), .rst_n(rst_n), .ce_n(ce_n),
        .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n),
        .exec_strobe(exec_strobe), .exec_opcode(exec_opcode), .exec_addr(exec_addr), .exec_data(exec_data));
    fsh_spi_host host (.clk(clk), .ce_n(ce_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so_out(so_out), .so_oe_n(so_oe_n));
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // Data bytes only count for programs; an erase leaves them stale
    function automatic logic ex_match(input logic [41:0] e);
        logic [15:0] dm;
        dm = (e[41:34] == OP_AUTO_INC_PROG) ? 16'hFFFF : (e[41:34] == OP_BYTE_PROG) ? 16'h00FF : 16'h0000;
        return ({exec_opcode, exec_addr} === e[41:16]) && ((exec_data & dm) === (e[15:0] & dm));
    endfunction : ex_match
    always @(posedge clk) begin
        if (host.rx_valid === 1'b1) begin
            n_compared++;
            if (exp_rd.size() == 0 || host.rx_byte !== exp_rd[0]) begin
                n_fail++;
                $display("[ERR] %0t status byte %h unexpected", $time, host.rx_byte);
            end
            if (exp_rd.size() != 0) void'(exp_rd.pop_front());
        end
        if (exec_strobe === 1'b1) begin
            n_compared++;
            if (exp_ex.size() == 0 || !ex_match(exp_ex[0])) begin
                n_fail++;
                $display("[ERR] %0t command %h at %h unexpected", $time, exec_opcode, exec_addr);
            end
            if (exp_ex.size() != 0) void'(exp_ex.pop_front());
        end
    end
    // Bytes are left-justified in b; only the first n go out
    task automatic send(input int n, input logic [39:0] b);
        for (int k = 0; k < 5; k++) host.tx[k] = b[39 - 8 * k -: 8];
        host.frame(n, 0);
    endtask : send
    task automatic rd(input logic [7:0] op, input logic [7:0] e, input int k);
        repeat (k) exp_rd.push_back(e);
        host.tx[0] = op;
        host.frame(k + 1, k);
    endtask : rd
    task automatic wait_ready();
        int i;
        for (i = 0; i < 20; i++) begin
            send(2, {OP_STATUS_READ, 32'h0});
            if (host.last_rx[SR_BUSY] === 1'b0) break;
        end
        if (i == 20) begin
            n_fail++;
            $display("[ERR] %0t busy never cleared", $time);
        end
    endtask : wait_ready
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] r1;
        logic [7:0] r2;
        logic [7:0] dv;
        rst_n = 1'b0;
        tc = '{'{OP_SECTOR_ERASE, 2'h0, 2'h0, 18'h30000, 1'b1}, '{OP_SECTOR_ERASE, 2'h1, 2'h0, 18'h30000, 1'b0},
            '{OP_SECTOR_ERASE, 2'h1, 2'h0, 18'h2F000, 1'b1}, '{OP_SECTOR_ERASE, 2'h2, 2'h0, 18'h20000, 1'b0},
            '{OP_SECTOR_ERASE, 2'h2, 2'h0, 18'h1F000, 1'b1}, '{OP_SECTOR_ERASE, 2'h3, 2'h0, 18'h00000, 1'b0},
            '{OP_CHIP_ERASE_A, 2'h1, 2'h0, 18'h00000, 1'b0}, '{OP_CHIP_ERASE_A, 2'h0, 2'h0, 18'h00000, 1'b1},
            '{OP_CHIP_ERASE_B, 2'h0, 2'h0, 18'h00000, 1'b1}, '{OP_SECTOR_ERASE, 2'h0, 2'h1, 18'h3F000, 1'b0},
            '{OP_BLOCK64_ERASE, 2'h0, 2'h2, 18'h00000, 1'b0}, '{OP_BLOCK32_ERASE, 2'h0, 2'h0, 18'h08000, 1'b1},
            '{OP_BYTE_PROG, 2'h1, 2'h0, 18'h30001, 1'b0}, '{OP_BYTE_PROG, 2'h0, 2'h0, 18'h30001, 1'b1}};
        void'($urandom(32'h0E9D));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OP_STATUS_READ, 8'h0C, 2);
        rd(OP_STATUS2_READ, 8'h00, 1);
        r1 = 8'($urandom) | 8'h80;
        r2 = 8'($urandom);
        dv = 8'($urandom);
        host.mode3 = 1'b1;
        host.pause_slot = 12;
        send(3, {OP_STATUS_WRITE, r1, r2, 16'h0});
        rd(OP_STATUS_READ, r1 & 8'h8C, 1);
        host.pause_slot = -1;
        rd(OP_STATUS2_READ, r2 & 8'h0C, 1);
        send(1, {OP_WRITE_ENABLE, 32'h0});
        rd(OP_STATUS_READ, (r1 & 8'h8C) | 8'h02, 1);
        host.set_wp(1'b0);
        send(3, {OP_STATUS_WRITE, 8'h00, 8'hFF, 16'h0});
        rd(OP_STATUS_READ, r1 & 8'h8C, 1);
        rd(OP_STATUS2_READ, r2 & 8'h0C, 1);
        host.set_wp(1'b1);
        host.mode3 = 1'b0;
        send(3, {OP_STATUS_WRITE, 32'h0});
        send(5, {OP_BYTE_PROG, 32'h000100A5});
        rd(OP_STATUS_READ, 8'h00, 1);
        foreach (tc[i]) begin
            send(3, {OP_STATUS_WRITE, 4'h0, tc[i].bp, 2'h0, 4'h0, tc[i].lk, 2'h0, 16'h0});
            send(1, {OP_WRITE_ENABLE, 32'h0});
            if (tc[i].ok) exp_ex.push_back({tc[i].op, tc[i].a, 8'h00, dv});
            send((tc[i].op == OP_CHIP_ERASE_A || tc[i].op == OP_CHIP_ERASE_B) ? 1 :
                (tc[i].op == OP_BYTE_PROG) ? 5 : 4, {tc[i].op, 6'h00, tc[i].a, dv});
            if (tc[i].ok) begin
                if (i == 0) begin
                    send(1, {OP_WRITE_DISABLE, 32'h0});
                    rd(OP_STATUS_READ, 8'h03, 1);
                end
                wait_ready();
                rd(OP_STATUS_READ, {4'h0, tc[i].bp, 2'h0}, 1);
            end else begin
                rd(OP_STATUS_READ, {4'h0, tc[i].bp, 2'h2}, 1);
            end
        end
        // Auto-increment: one word below the top, then the last word of the array
        send(1, {OP_WRITE_ENABLE, 32'h0});
        exp_ex.push_back({OP_AUTO_INC_PROG, 18'h3FFFC, r2, dv});
        host.tx = '{OP_AUTO_INC_PROG, 8'h03, 8'hFF, 8'hFC, dv, r2, 8'h00, 8'h00};
        host.frame(6, 0);
        wait_ready();
        rd(OP_STATUS_READ, 8'h42, 1);
        exp_ex.push_back({OP_AUTO_INC_PROG, 18'h3FFFE, r1, dv});
        send(3, {OP_AUTO_INC_PROG, dv, r1, 16'h0});
        wait_ready();
        rd(OP_STATUS_READ, 8'h00, 1);
        if (exp_rd.size() != 0 || exp_ex.size() != 0) begin
            n_fail++;
            $display("[ERR] %0t expected results never appeared", $time);
        end
        tally_and_finish();
    end
endmodule : fsh_flash_ctrl_tb_top
bind fsh_flash_ctrl fsh_flash_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .ce_n(ce_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .exec_strobe(exec_strobe),
    .exec_opcode(exec_opcode), .exec_addr(exec_addr), .exec_data(exec_data));

// >>> verification/fsh_spi_host.sv
/* Behavioural SPI host that drives the flash pins, mode 0 or 3.
   Assumes clk at 100 ns; serial clock is 8 clk per bit (800 ns). */
`timescale 1ns/1ps
module fsh_spi_host (
    input wire logic clk,
    output logic ce_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    output logic wp_n,
    input wire logic so_out,
    input wire logic so_oe_n
);
    logic [7:0] tx [8];
    logic [7:0] rx_byte;
    logic [7:0] last_rx;
    logic rx_valid;
    logic mode3;
    int pause_slot;
    initial begin
        ce_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
        rx_valid = 1'b0;
        mode3 = 1'b0;
        pause_slot = -1;
    end
    // Select stays low across the pause
    task automatic pause_here();
        repeat (2) @(posedge clk);
        hold_n <= 1'b0;
        repeat (2) @(posedge clk);
        sck <= 1'b0;
        repeat (8) @(posedge clk);
        repeat (2) begin
            sck <= 1'b1;
            si <= 1'($urandom);
            repeat (4) @(posedge clk);
            sck <= 1'b0;
            repeat (4) @(posedge clk);
        end
        sck <= 1'b1;
        repeat (2) @(posedge clk);
        hold_n <= 1'b1; // Raised before any later frame
        repeat (2) @(posedge clk);
    endtask : pause_here
    task automatic frame(input int n, input int nchk);
        int s;
        logic [7:0] r;
        r = 8'h00;
        @(posedge clk);
        sck <= mode3; // Idle level of the chosen mode
        repeat (2) @(posedge clk);
        ce_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (s = 0; s < n * 8; s++) begin
            sck <= 1'b0;
            si <= tx[s / 8][7 - s % 8]; // MSB first
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            if (s == pause_slot) pause_here();
            repeat (4) @(posedge clk);
            r = {r[6:0], so_out};
            if (s % 8 == 7) begin
                last_rx = r;
                if (s / 8 >= n - nchk) begin
                    rx_byte <= r;
                    rx_valid <= 1'b1;
                    @(posedge clk);
                    rx_valid <= 1'b0;
                end
            end
        end
        if (!mode3) begin
            sck <= 1'b0;
            repeat (4) @(posedge clk);
        end
        ce_n <= 1'b1;
        si <= ~si; // A released line must not show the last bit
        repeat (4) @(posedge clk);
    endtask : frame
    task automatic set_wp(input logic v);
        @(posedge clk);
        wp_n <= v;
        repeat (4) @(posedge clk);
    endtask : set_wp
endmodule : fsh_spi_host
